// ==== src/imupr_regs.sv ====
// What this block does
// [RULE1] Filter bank A coefficients 0 to 59 live at word addresses 0x02 to 0x7E of page 0x05, read/write.
// [RULE2] Filter bank B coefficients 0 to 59 live on page 0x07 and 60 to 119 on page 0x08, from address 0x02.
// [RULE3] Filter bank C coefficients 0 to 59 live on page 0x09 and 60 to 119 on page 0x0A, read/write.
// [RULE4] Filter bank D lives on pages 0x0B and 0x0C, and bank A's upper half on page 0x06.
// [RULE5] After start-up the page select holds 0x0000, so page 0 is active.
// [RULE6] Output data, status and identification registers sit on page 0; this block holds only the six results there.
// [RULE7] Rate and acceleration results are 32-bit twos complement spread over two 16-bit words.
// [RULE8] The upper 16 bits go to the primary word and the lower 16 bits to a companion word.
// [RULE9] With decimation at 0x0000 the lower companion words stay inactive at zero.
// [RULE10] Bit 3 of the orientation config picks body or navigation frame, navigation when 0.
// [RULE11] Acceleration results include gravity, so a flat unit shows about 1 g on z.
// [RULE12] Rate upper words are 0.02 deg/s per LSB at 0x12, 0x16 and 0x1A.
// [RULE13] Rate lower words carry 0.01 deg/s at their MSB, y and z at 0x14 and 0x18.
// [RULE14] Acceleration upper words are 0.8 mg per LSB, y and z at 0x22 and 0x26.
// [RULE15] Acceleration lower words carry 0.4 mg at their MSB, x at 0x1C.
// [RULE16] GPIO control bits 7 to 4 mirror the digital I/O line levels with no default.
// [RULE17] The host writes the page select at 0x00 before touching another page.
`timescale 1ns/1ps

module imupr_regs (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_SPI_SCLK,
    input  wire logic        I_SPI_CS_N,
    input  wire logic        I_SPI_MOSI,
    output logic             O_SPI_MISO,
    output logic             O_SPI_MISO_OE_N,
    input  wire logic        I_SAMPLE_VALID,
    input  wire logic [31:0] I_RATE_X,
    input  wire logic [31:0] I_RATE_Y,
    input  wire logic [31:0] I_RATE_Z,
    input  wire logic [31:0] I_ACCEL_X,
    input  wire logic [31:0] I_ACCEL_Y,
    input  wire logic [31:0] I_ACCEL_Z,
    input  wire logic [3:0]  I_DIGITAL_IO_LINES,
    output logic [15:0]      O_PAGE_SELECT,
    output logic [15:0]      O_DECIMATION_SETTING,
    output logic             O_NAV_FRAME,
    output logic [3:0]       O_GPIO_CONTROL
);

    // ------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------
    logic       sclk_s1_reg;
    logic       sclk_s2_reg;
    logic       sclk_s3_reg;
    logic       cs_s1_reg;
    logic       cs_s2_reg;
    logic       mosi_s1_reg;
    logic       mosi_s2_reg;
    logic [3:0] io_s1_reg;
    logic [3:0] io_s2_reg;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            sclk_s1_reg <= 1'b1;
            sclk_s2_reg <= 1'b1;
            sclk_s3_reg <= 1'b1;
            cs_s1_reg   <= 1'b1;
            cs_s2_reg   <= 1'b1;
            mosi_s1_reg <= 1'b0;
            mosi_s2_reg <= 1'b0;
            io_s1_reg   <= 4'h0;
            io_s2_reg   <= 4'h0;
        end else begin
            sclk_s1_reg <= I_SPI_SCLK;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            cs_s1_reg   <= I_SPI_CS_N;
            cs_s2_reg   <= cs_s1_reg;
            mosi_s1_reg <= I_SPI_MOSI;
            mosi_s2_reg <= mosi_s1_reg;
            io_s1_reg   <= I_DIGITAL_IO_LINES;
            io_s2_reg   <= io_s1_reg;
        end
    end

    // Edges seen only after the second stage
    wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
    wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
    wire cs_active = ~cs_s2_reg;

    // ------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------
    imupr_pkg::imupr_spi_state_t state_reg;
    imupr_pkg::imupr_spi_state_t state_next;
    logic [3:0]  bit_cnt_reg;
    logic [15:0] rx_reg;
    logic [15:0] tx_reg;
    logic [15:0] rd_data_reg;
    logic        frame_done_reg;

    always_comb begin
        case (state_reg)
            imupr_pkg::IMUPR_IDLE: begin
                state_next = cs_active ? imupr_pkg::IMUPR_SHIFT : imupr_pkg::IMUPR_IDLE;
            end
            imupr_pkg::IMUPR_SHIFT: begin
                state_next = cs_active ? imupr_pkg::IMUPR_SHIFT : imupr_pkg::IMUPR_IDLE;
            end
            default: begin
                state_next = imupr_pkg::IMUPR_IDLE;
            end
        endcase
    end

    wire in_shift  = (state_reg == imupr_pkg::IMUPR_SHIFT) & cs_active;
    wire start     = (state_reg == imupr_pkg::IMUPR_IDLE) & cs_active;
    wire bit_last  = (bit_cnt_reg == imupr_pkg::FRAME_LAST_BIT);
    wire shift_out = in_shift & sclk_fall & (bit_cnt_reg != 4'h0);

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            state_reg       <= imupr_pkg::IMUPR_IDLE;
            bit_cnt_reg     <= 4'h0;
            rx_reg          <= 16'h0000;
            tx_reg          <= 16'h0000;
            frame_done_reg  <= 1'b0;
            O_SPI_MISO      <= 1'b0;
            O_SPI_MISO_OE_N <= 1'b1;
        end else begin
            state_reg       <= state_next;
            frame_done_reg  <= in_shift & sclk_rise & bit_last;
            O_SPI_MISO_OE_N <= ~cs_active;
            if (start) begin
                bit_cnt_reg <= 4'h0;
                tx_reg      <= rd_data_reg;
                O_SPI_MISO  <= rd_data_reg[15];
            end else if (in_shift & sclk_rise) begin
                rx_reg      <= {rx_reg[14:0], mosi_s2_reg};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (shift_out) begin
                tx_reg      <= {tx_reg[14:0], 1'b0};
                O_SPI_MISO  <= tx_reg[14];
            end
        end
    end

    // ------------------------------------------------
    // Frame decode
    // ------------------------------------------------
    // Byte writes; a read answers in the next frame
    wire       fr_write = rx_reg[15];
    wire [6:0] fr_addr  = rx_reg[14:8];
    wire [7:0] fr_data  = rx_reg[7:0];
    wire [6:0] fr_word  = {fr_addr[6:1], 1'b0};
    wire       fr_hi    = fr_addr[0];
    wire       wr_en    = frame_done_reg & fr_write;
    wire       rd_en    = frame_done_reg & ~fr_write;

    logic [15:0] page_reg;
    logic [15:0] decim_reg;
    logic [15:0] orient_reg;
    logic [3:0]  gpio_reg;

    wire on_page0 = (page_reg == imupr_pkg::PAGE_OUTPUT);
    wire on_ctrl  = (page_reg == imupr_pkg::PAGE_CONTROL);

    // Bank page window
    // [RULE1] [RULE2] [RULE3] [RULE4] bank page span
    wire coef_page = (page_reg >= imupr_pkg::PAGE_BANK_A_LOW) & (page_reg <= imupr_pkg::PAGE_BANK_D_HIGH);
    wire coef_addr = (fr_addr >= imupr_pkg::ADDR_COEF_FIRST) & (fr_word <= imupr_pkg::ADDR_COEF_LAST);
    wire [3:0] coef_pg_full = page_reg[3:0] - imupr_pkg::PAGE_BANK_A_LOW[3:0];
    wire [8:0] coef_idx = {coef_pg_full[2:0], fr_addr[6:1]};
    wire coef_hit = coef_page & coef_addr;

    wire wr_page   = wr_en & (fr_word == imupr_pkg::ADDR_PAGE_SELECT);
    wire wr_decim  = wr_en & on_ctrl & (fr_word == imupr_pkg::ADDR_DECIMATION);
    wire wr_orient = wr_en & on_ctrl & (fr_word == imupr_pkg::ADDR_ORIENT_CONFIG);
    wire wr_gpio   = wr_en & on_ctrl & (fr_word == imupr_pkg::ADDR_GPIO_CONTROL) & ~fr_hi;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic hi, input logic [7:0] data);
        merge = hi ? {data, old[7:0]} : {old[15:8], data};
    endfunction : merge

    // ------------------------------------------------
    // Control registers
    // ------------------------------------------------
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            // [RULE5] page 0 after start-up
            page_reg    <= imupr_pkg::RESET_PAGE;
            decim_reg   <= imupr_pkg::RESET_DECIMATION;
            orient_reg  <= imupr_pkg::RESET_ORIENT;
            gpio_reg    <= imupr_pkg::RESET_GPIO;
            O_NAV_FRAME <= 1'b1;
        end else begin
            if (wr_page) begin
                page_reg <= merge(page_reg, fr_hi, fr_data);
            end
            if (wr_decim) begin
                decim_reg <= merge(decim_reg, fr_hi, fr_data);
            end
            if (wr_orient) begin
                orient_reg <= merge(orient_reg, fr_hi, fr_data);
            end
            if (wr_gpio) begin
                gpio_reg <= fr_data[3:0];
            end
            // [RULE10] zero selects navigation frame
            O_NAV_FRAME <= ~orient_reg[imupr_pkg::ORIENT_FRAME_BIT];
        end
    end

    assign O_PAGE_SELECT        = page_reg;
    assign O_DECIMATION_SETTING = decim_reg;
    assign O_GPIO_CONTROL       = gpio_reg;

    // ------------------------------------------------
    // Coefficient store
    // ------------------------------------------------
    // No reset: contents stand for the nonvolatile copy
    logic [15:0] coef_mem [512];

    always_ff @(posedge I_SYS_CLK) begin
        // [RULE1] [RULE3] coefficient byte write
        if (wr_en & coef_hit) begin
            coef_mem[coef_idx] <= merge(coef_mem[coef_idx], fr_hi, fr_data);
        end
    end

    // ------------------------------------------------
    // Page 0 results
    // ------------------------------------------------
    logic [15:0] upper_reg [imupr_pkg::RESULT_COUNT];
    logic [15:0] lower_reg [imupr_pkg::RESULT_COUNT];
    wire  [31:0] result_in [imupr_pkg::RESULT_COUNT];
    wire  [15:0] res_rd    [imupr_pkg::RESULT_COUNT];
    wire  [15:0] res_or    [imupr_pkg::RESULT_COUNT + 1];

    // [RULE11] gravity passes through untouched
    assign result_in[0] = I_RATE_X;
    assign result_in[1] = I_RATE_Y;
    assign result_in[2] = I_RATE_Z;
    assign result_in[3] = I_ACCEL_X;
    assign result_in[4] = I_ACCEL_Y;
    assign result_in[5] = I_ACCEL_Z;
    assign res_or[0]    = 16'h0000;

    // [RULE9] lower words idle at full rate
    wire lower_off = (decim_reg == imupr_pkg::DECIM_MAX_RATE);

    for (genvar i = 0; i < imupr_pkg::RESULT_COUNT; i++) begin : g_res
        always_ff @(posedge I_SYS_CLK) begin
            if (I_RESET) begin
                upper_reg[i] <= 16'h0000;
                lower_reg[i] <= 16'h0000;
            end else if (I_SAMPLE_VALID) begin
                // [RULE7] [RULE8] split 32-bit result
                upper_reg[i] <= result_in[i][31:16];
                lower_reg[i] <= lower_off ? imupr_pkg::LOWER_IDLE : result_in[i][15:0];
            end
        end
        // [RULE12] [RULE13] [RULE14] [RULE15] word placement
        assign res_rd[i] = (fr_word == imupr_pkg::RESULT_LOWER_ADDR[i]) ? lower_reg[i] :
                           (fr_word == imupr_pkg::RESULT_UPPER_ADDR[i]) ? upper_reg[i] : 16'h0000;
        assign res_or[i + 1] = res_or[i] | res_rd[i];
    end

    // ------------------------------------------------
    // Read selection
    // ------------------------------------------------
    // [RULE16] upper nibble mirrors the lines
    wire [15:0] ctrl_rd =
        (fr_word == imupr_pkg::ADDR_GPIO_CONTROL)  ? {8'h00, io_s2_reg, gpio_reg} :
        (fr_word == imupr_pkg::ADDR_DECIMATION)    ? decim_reg :
        (fr_word == imupr_pkg::ADDR_ORIENT_CONFIG) ? orient_reg : 16'h0000;

    // [RULE6] page 0 holds the results
    wire [15:0] rd_mux =
        (fr_word == imupr_pkg::ADDR_PAGE_SELECT) ? page_reg :
        on_page0 ? res_or[imupr_pkg::RESULT_COUNT] :
        on_ctrl  ? ctrl_rd :
        coef_hit ? coef_mem[coef_idx] : 16'h0000;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            rd_data_reg <= 16'h0000;
        end else if (frame_done_reg) begin
            rd_data_reg <= rd_en ? rd_mux : 16'h0000;
        end
    end

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RESET);

    AST_PAGE_START: assert property ( // [RULE5]
        $fell(I_RESET) |-> (page_reg == 16'h0000) && (O_PAGE_SELECT == 16'h0000)
    ) else $error("page select not zero after reset");

    AST_COEF_STORE: assert property ( // [RULE1]
        wr_en && coef_hit && !fr_hi |=> coef_mem[$past(coef_idx)][7:0] == $past(fr_data)
    ) else $error("coefficient byte not stored");

    AST_BANK_PAGES: assert property ( // [RULE2]
        wr_en && coef_hit && (page_reg == 16'h0008) |-> coef_idx[8:6] == 3'h3
    ) else $error("bank page maps to wrong block");

    AST_BANK_C_PAGES: assert property ( // [RULE3]
        wr_en && coef_hit && (page_reg == 16'h0009) |-> coef_idx[8:6] == 3'h4
    ) else $error("bank C page maps to wrong block");

    AST_BANK_D_PAGES: assert property ( // [RULE4]
        wr_en && coef_hit && (page_reg == 16'h000C) |-> coef_idx[8:6] == 3'h7
    ) else $error("bank D upper page maps to wrong block");

    AST_UPPER_WORD: assert property ( // [RULE8]
        I_SAMPLE_VALID |=> upper_reg[0] == $past(I_RATE_X[31:16])
    ) else $error("upper word not captured");

    AST_LOWER_IDLE: assert property ( // [RULE9]
        I_SAMPLE_VALID && (decim_reg == 16'h0000) |=> lower_reg[3] == 16'h0000
    ) else $error("lower word active at full rate");

    AST_LOWER_WORD: assert property ( // [RULE13]
        I_SAMPLE_VALID && (decim_reg != 16'h0000) |=> lower_reg[1] == $past(I_RATE_Y[15:0])
    ) else $error("lower word not captured");

    AST_NAV_FRAME: assert property ( // [RULE10]
        wr_orient && !fr_hi |=> ##1 O_NAV_FRAME == !$past(fr_data[3], 2)
    ) else $error("frame select not followed");

    AST_RATE_READ: assert property ( // [RULE12]
        rd_en && on_page0 && (fr_addr == 7'h12) |=> rd_data_reg == $past(upper_reg[0])
    ) else $error("rate upper word read wrong");

    AST_GPIO_MIRROR: assert property ( // [RULE16]
        rd_en && on_ctrl && (fr_word == 7'h08) |=> rd_data_reg[7:4] == $past(io_s2_reg)
    ) else $error("gpio mirror bits wrong");

    COV_COEF_WRITE: cover property (wr_en && coef_hit);
    COV_PAGE0_READ: cover property (rd_en && on_page0 ##[1:40] start);
    COV_LOWER_OFF:  cover property (I_SAMPLE_VALID && lower_off);
    COV_BODY_FRAME: cover property (!O_NAV_FRAME);

endmodule : imupr_regs

// ==== pkg/imupr_pkg.sv ====
package imupr_pkg;

    // ------------------------------------------------
    // Pages
    // ------------------------------------------------
    localparam logic [15:0] PAGE_OUTPUT      = 16'h0000;
    localparam logic [15:0] PAGE_CONTROL     = 16'h0003;
    localparam logic [15:0] PAGE_BANK_A_LOW  = 16'h0005;
    localparam logic [15:0] PAGE_BANK_A_HIGH = 16'h0006;
    localparam logic [15:0] PAGE_BANK_B_LOW  = 16'h0007;
    localparam logic [15:0] PAGE_BANK_B_HIGH = 16'h0008;
    localparam logic [15:0] PAGE_BANK_C_LOW  = 16'h0009;
    localparam logic [15:0] PAGE_BANK_C_HIGH = 16'h000A;
    localparam logic [15:0] PAGE_BANK_D_LOW  = 16'h000B;
    localparam logic [15:0] PAGE_BANK_D_HIGH = 16'h000C;

    // ------------------------------------------------
    // Byte addresses within a page
    // ------------------------------------------------
    localparam logic [6:0] ADDR_PAGE_SELECT   = 7'h00;
    localparam logic [6:0] ADDR_COEF_FIRST    = 7'h02;
    localparam logic [6:0] ADDR_COEF_LAST     = 7'h7E;
    localparam logic [6:0] ADDR_GPIO_CONTROL  = 7'h08;
    localparam logic [6:0] ADDR_DECIMATION    = 7'h0C;
    localparam logic [6:0] ADDR_ORIENT_CONFIG = 7'h50;

    // Rate x/y/z then accel x/y/z
    localparam int RESULT_COUNT = 6;
    localparam logic [6:0] RESULT_LOWER_ADDR [RESULT_COUNT] = '{7'h10, 7'h14, 7'h18, 7'h1C, 7'h20, 7'h24};
    localparam logic [6:0] RESULT_UPPER_ADDR [RESULT_COUNT] = '{7'h12, 7'h16, 7'h1A, 7'h1E, 7'h22, 7'h26};

    // ------------------------------------------------
    // Values after reset and fields
    // ------------------------------------------------
    localparam logic [15:0] RESET_PAGE       = 16'h0000;
    localparam logic [15:0] RESET_DECIMATION = 16'h0000;
    localparam logic [15:0] RESET_ORIENT     = 16'h0200;
    localparam logic [3:0]  RESET_GPIO       = 4'hD;
    localparam logic [15:0] DECIM_MAX_RATE   = 16'h0000;
    localparam logic [15:0] LOWER_IDLE       = 16'h0000;
    localparam int          ORIENT_FRAME_BIT = 3;
    localparam logic [3:0]  FRAME_LAST_BIT   = 4'hF;

    typedef enum logic [0:0] {
        IMUPR_IDLE  = 1'b0,
        IMUPR_SHIFT = 1'b1
    } imupr_spi_state_t;

endpackage : imupr_pkg

// ==== verification/imupr_spi_host.sv ====
`timescale 1ns/1ps

module imupr_spi_host (
    input  wire logic        i_clk,
    input  wire logic        i_miso,
    input  wire logic        i_miso_oe_n,
    output logic             o_sclk,
    output logic             o_cs_n,
    output logic             o_mosi,
    output logic             o_done,
    output logic [15:0]      o_rx_word
);
    // ------------------------------------------------
    // Link timing
    // ------------------------------------------------
    // Half of the 80 ns link period in system cycles
    localparam int HALF = 8;

    initial begin
        o_sclk    = 1'b1;
        o_cs_n    = 1'b1;
        o_mosi    = 1'b0;
        o_done    = 1'b0;
        o_rx_word = 16'h0000;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick

    // ------------------------------------------------
    // One 16-bit mode 3 frame
    // ------------------------------------------------
    task automatic xfer(input logic [15:0] tx);
        logic [15:0] rx;
        rx = 16'h0000;
        o_cs_n <= 1'b0;
        o_mosi <= tx[15];
        tick(HALF);
        for (int b = 15; b >= 0; b--) begin
            o_sclk <= 1'b0;
            if (b != 15) begin
                o_mosi <= tx[b];
            end
            tick(HALF);
            o_sclk <= 1'b1;
            // Undriven line must not pass as data
            rx[b] = i_miso_oe_n ? 1'bx : i_miso;
            tick(HALF);
        end
        o_cs_n    <= 1'b1;
        // Released data line shows no stale bit
        o_mosi    <= ~o_mosi;
        o_rx_word <= rx;
        o_done    <= 1'b1;
        tick(1);
        o_done <= 1'b0;
        tick(HALF);
    endtask : xfer
endmodule : imupr_spi_host

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`define CHECK(got, want) begin checks++; if ((got) !== (want)) begin bad_count++; \
    $display("unexpected at %0t: got %h want %h", $time, (got), (want)); end end

module tb_top;
    typedef struct packed {logic chk; logic [15:0] val;} imupr_exp_t;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic        valid     = 1'b0;
    logic [3:0]  dio       = 4'h0;
    logic [31:0] res [6]   = '{default: 32'h0000_0000};
    logic        sclk, cs_n, mosi, miso, miso_oe_n, done, nav;
    logic [15:0] rx_word, page_sel, decim;
    logic [3:0]  gpio;
    logic [15:0] cf [8][2];
    int          bad_count = 0;
    int          checks    = 0;
    int          cycles    = 0;
    imupr_exp_t  exp_q [$];
    imupr_exp_t  pend      = '0;

    always #2.5 clk = ~clk;

    imupr_spi_host imupr_spi_host_i (
        .i_clk       (clk),
        .i_miso      (miso),
        .i_miso_oe_n (miso_oe_n),
        .o_sclk      (sclk),
        .o_cs_n      (cs_n),
        .o_mosi      (mosi),
        .o_done      (done),
        .o_rx_word   (rx_word)
    );

    imupr_regs imupr_regs_i (
        .I_SYS_CLK            (clk),
        .I_RESET              (rst),
        .I_SPI_SCLK           (sclk),
        .I_SPI_CS_N           (cs_n),
        .I_SPI_MOSI           (mosi),
        .O_SPI_MISO           (miso),
        .O_SPI_MISO_OE_N      (miso_oe_n),
        .I_SAMPLE_VALID       (valid),
        .I_RATE_X             (res[0]),
        .I_RATE_Y             (res[1]),
        .I_RATE_Z             (res[2]),
        .I_ACCEL_X            (res[3]),
        .I_ACCEL_Y            (res[4]),
        .I_ACCEL_Z            (res[5]),
        .I_DIGITAL_IO_LINES   (dio),
        .O_PAGE_SELECT        (page_sel),
        .O_DECIMATION_SETTING (decim),
        .O_NAV_FRAME          (nav),
        .O_GPIO_CONTROL       (gpio)
    );

    // ------------------------------------------------
    // Bus tasks
    // ------------------------------------------------
    task automatic frame(input logic [15:0] tx);
        exp_q.push_back(pend);
        imupr_spi_host_i.xfer(tx);
    endtask : frame

    task automatic wr8(input logic [6:0] a, input logic [7:0] d);
        frame({1'b1, a, d});
        pend = {1'b1, 16'h0000};
    endtask : wr8

    task automatic wr16(input logic [6:0] a, input logic [15:0] d);
        wr8(a, d[7:0]);
        wr8(a | 7'h01, d[15:8]);
    endtask : wr16

    // Answer arrives in the following frame
    task automatic rd(input logic [6:0] a, input logic [15:0] want);
        frame({1'b0, a, 8'h00});
        pend = {1'b1, want};
    endtask : rd

    task automatic page(input logic [15:0] p);
        wr16(imupr_pkg::ADDR_PAGE_SELECT, p);
    endtask : page

    task automatic capture();
        @(posedge clk);
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
    endtask : capture

    task automatic check_results(input logic lower_on);
        page(imupr_pkg::PAGE_OUTPUT);
        for (int i = 0; i < imupr_pkg::RESULT_COUNT; i++) begin
            rd(imupr_pkg::RESULT_UPPER_ADDR[i], res[i][31:16]);
            rd(imupr_pkg::RESULT_LOWER_ADDR[i], lower_on ? res[i][15:0] : imupr_pkg::LOWER_IDLE);
        end
    endtask : check_results

    task automatic end_of_test();
        $display("checks %0d, bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------
    // Watchers
    // ------------------------------------------------
    always @(posedge clk) begin
        imupr_exp_t e;
        if (done === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e.chk) begin
                `CHECK(rx_word, e.val)
            end
        end
    end

    // Ceiling well above the roughly 38k cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            bad_count++;
            $display("unexpected at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    initial begin
        void'($urandom(20718));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        `CHECK(page_sel, imupr_pkg::RESET_PAGE)
        `CHECK(nav, 1'b1)
        rd(imupr_pkg::ADDR_PAGE_SELECT, 16'h0000);
        // Each page keeps its own words, no aliasing
        for (int p = 0; p < 8; p++) begin
            page(imupr_pkg::PAGE_BANK_A_LOW + 16'(p));
            cf[p][0] = 16'($urandom());
            cf[p][1] = 16'($urandom());
            wr16(imupr_pkg::ADDR_COEF_FIRST, cf[p][0]);
            wr16(imupr_pkg::ADDR_COEF_LAST, cf[p][1]);
        end
        for (int p = 0; p < 8; p++) begin
            page(imupr_pkg::PAGE_BANK_A_LOW + 16'(p));
            `CHECK(page_sel, imupr_pkg::PAGE_BANK_A_LOW + 16'(p))
            rd(imupr_pkg::ADDR_PAGE_SELECT, imupr_pkg::PAGE_BANK_A_LOW + 16'(p));
            rd(imupr_pkg::ADDR_COEF_FIRST, cf[p][0]);
            rd(imupr_pkg::ADDR_COEF_LAST, cf[p][1]);
        end
        page(imupr_pkg::PAGE_CONTROL);
        dio <= 4'($urandom());
        rd(imupr_pkg::ADDR_ORIENT_CONFIG, imupr_pkg::RESET_ORIENT);
        wr8(imupr_pkg::ADDR_ORIENT_CONFIG, 8'h08);
        `CHECK(nav, 1'b0)
        wr8(imupr_pkg::ADDR_ORIENT_CONFIG, 8'h00);
        `CHECK(nav, 1'b1)
        rd(imupr_pkg::ADDR_GPIO_CONTROL, {8'h00, dio, imupr_pkg::RESET_GPIO});
        wr8(imupr_pkg::ADDR_GPIO_CONTROL, 8'h05);
        `CHECK(gpio, 4'h5)
        wr16(imupr_pkg::ADDR_DECIMATION, 16'h0004);
        `CHECK(decim, 16'h0004)
        foreach (res[i]) res[i] <= $urandom();
        capture();
        check_results(1'b1);
        // Result words are read-only
        wr16(imupr_pkg::RESULT_UPPER_ADDR[0], ~res[0][31:16]);
        rd(imupr_pkg::RESULT_UPPER_ADDR[0], res[0][31:16]);
        page(imupr_pkg::PAGE_CONTROL);
        wr16(imupr_pkg::ADDR_DECIMATION, imupr_pkg::DECIM_MAX_RATE);
        `CHECK(decim, 16'h0000)
        // Flat unit: 1 g is 1250 counts of 0.8 mg
        foreach (res[i]) res[i] <= (i == 5) ? 32'h04E2_0000 : $urandom();
        capture();
        check_results(1'b0);
        rd(7'h26, 16'h04E2);
        page(16'h0004);
        rd(7'h20, 16'h0000);
        frame(16'h0000);
        end_of_test();
    end
endmodule : tb_top
